// >>> verilog/cpp_pkg.sv
// Package for the complementary PWM and phase counting timer block
package cpp_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_C3 = 8'h08;
  localparam logic [7:0] ADDR_C4 = 8'h0C;
  localparam logic [7:0] ADDR_PER = 8'h10;
  localparam logic [7:0] ADDR_PT1 = 8'h14;
  localparam logic [7:0] ADDR_BF1 = 8'h20;
  localparam logic [7:0] ADDR_C2 = 8'h2C;
  localparam logic [7:0] ADDR_C2GA = 8'h30;
  localparam logic [7:0] ADDR_C2GB = 8'h34;
  localparam logic [7:0] ADDR_C2CTRL = 8'h38;
  localparam logic [7:0] ADDR_STEP = 8'h04;
  // Control register fields
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_RUN3 = 2;
  localparam int CTRL_RUN4 = 3;
  localparam int CTRL_RUN2 = 4;
  localparam int CTRL_PHASE = 5;
  localparam int CTRL_BUF = 6;
  localparam int CTRL_PSC_LSB = 8;
  localparam logic [1:0] CMD_COMP = 2'b10;
  // Status register fields
  localparam int ST_MATCH_A3 = 0;
  localparam int ST_OVF4 = 1;
  localparam int ST_MATCH_A2 = 2;
  localparam int ST_MATCH_B2 = 3;
  localparam int ST_OVF2 = 4;
  localparam int ST_DIR = 8;
  // Channel 2 counter clear selections
  localparam logic [1:0] CLR_NONE = 2'b00;
  localparam logic [1:0] CLR_GA = 2'b01;
  localparam logic [1:0] CLR_GB = 2'b10;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  // Counting direction of the channel 3/4 pair
  typedef enum logic {CPP_UP = 1'b0, CPP_DOWN = 1'b1} cpp_dir_t;
  // The six complementary PWM pins
  typedef struct packed {
    logic out1;
    logic out1_comp;
    logic out2;
    logic out2_comp;
    logic out3;
    logic out3_comp;
  } cpp_pwm_t;
endpackage

// >>> verilog/cpp_timer.sv
// Complementary PWM and phase counting timer with AHB-Lite registers
`timescale 1ns/1ps
module cpp_timer #(
  parameter int CW = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic quad_input_a,
  input wire logic quad_input_b,
  output cpp_pkg::cpp_pwm_t pwm,
  output logic pwm_oe
);
  logic [31:0] ctrl_reg, rd_reg, rd_mux;
  logic [7:0] wa_reg;
  logic wr_pend_reg;
  logic [2:0] div_reg;
  logic [CW-1:0] c3_reg, c4_reg, per_reg, c2_reg, ga2_reg, gb2_reg;
  logic [CW-1:0] pt_reg [3];
  logic [CW-1:0] bf_reg [3];
  logic [2:0] pos_reg, neg_reg, m3, m4, wr_pt, wr_bf;
  logic [1:0] clr2_reg;
  logic [4:0] stat_reg, stat_set, stat_next;
  cpp_pkg::cpp_dir_t dir_reg;
  logic a_prev_reg, b_prev_reg;

  // Bus slave answers at once, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_reg;
  wire take = hsel & hready & htrans[1] & (hsize == 3'b010);
  wire wr_en = wr_pend_reg;
  wire wr_ctrl = wr_en && (wa_reg == cpp_pkg::ADDR_CTRL);
  wire wr_stat = wr_en && (wa_reg == cpp_pkg::ADDR_STAT);
  wire wr_c3 = wr_en && (wa_reg == cpp_pkg::ADDR_C3);
  wire wr_c4 = wr_en && (wa_reg == cpp_pkg::ADDR_C4);
  wire wr_per = wr_en && (wa_reg == cpp_pkg::ADDR_PER);
  wire wr_c2 = wr_en && (wa_reg == cpp_pkg::ADDR_C2);
  wire wr_ga2 = wr_en && (wa_reg == cpp_pkg::ADDR_C2GA);
  wire wr_gb2 = wr_en && (wa_reg == cpp_pkg::ADDR_C2GB);
  wire wr_clr2 = wr_en && (wa_reg == cpp_pkg::ADDR_C2CTRL);
  wire [CW-1:0] wdat = hwdata[CW-1:0];

  // Count clock enable from the prescaler select
  wire [1:0] psc = ctrl_reg[cpp_pkg::CTRL_PSC_LSB +: 2];
  wire [2:0] psc_mask = 3'((4'h1 << psc) - 4'h1);
  wire tick = (div_reg & psc_mask) == 3'h0;

  // Complementary mode control
  wire comp_mode = ctrl_reg[cpp_pkg::CTRL_CMD_LSB +: 2] == cpp_pkg::CMD_COMP;
  wire comp_run = comp_mode & ctrl_reg[cpp_pkg::CTRL_RUN3] & ctrl_reg[cpp_pkg::CTRL_RUN4];
  wire step = comp_run & tick;
  wire up = dir_reg == cpp_pkg::CPP_UP;
  wire turn_down = step & up & (c3_reg == per_reg);
  wire underflow = step & ~up & (c4_reg == cpp_pkg::CNT_RST);
  wire xfer = ctrl_reg[cpp_pkg::CTRL_BUF] & (turn_down | underflow);
  assign pwm_oe = comp_mode;

  // Per-phase matches; above the period only period+1 (channel 3 overshoot) and all-ones (channel 4 undershoot) can match
  // Channel 3 starts ahead, so its match leads and trails the pair
  for (genvar i = 0; i < 3; i++) begin : g_phase
    assign m3[i] = step & (c3_reg == pt_reg[i]);
    assign m4[i] = step & (c4_reg == pt_reg[i]);
    assign wr_pt[i] = wr_en && (wa_reg == 8'(cpp_pkg::ADDR_PT1 + cpp_pkg::ADDR_STEP * i));
    assign wr_bf[i] = wr_en && (wa_reg == 8'(cpp_pkg::ADDR_BF1 + cpp_pkg::ADDR_STEP * i));
  end

  // Output pins; every pair's positive from channel 4 matches, its complement from channel 3 matches
  assign pwm.out1 = pos_reg[0];
  assign pwm.out1_comp = neg_reg[0];
  assign pwm.out2 = pos_reg[1];
  assign pwm.out2_comp = neg_reg[1];
  assign pwm.out3 = pos_reg[2];
  assign pwm.out3_comp = neg_reg[2];

  // Quadrature decode, inputs already synchronous
  wire ph_run = ctrl_reg[cpp_pkg::CTRL_PHASE] & ctrl_reg[cpp_pkg::CTRL_RUN2];
  wire a_rise = quad_input_a & ~a_prev_reg;
  wire a_fall = ~quad_input_a & a_prev_reg;
  wire b_rise = quad_input_b & ~b_prev_reg;
  wire b_fall = ~quad_input_b & b_prev_reg;
  wire q_up = (a_rise & quad_input_b) | (a_fall & ~quad_input_b) |
              (b_rise & ~quad_input_a) | (b_fall & quad_input_a);
  wire q_dn = (a_rise & ~quad_input_b) | (a_fall & quad_input_b) |
              (b_rise & quad_input_a) | (b_fall & ~quad_input_a);
  wire c2_step = ph_run & (q_up ^ q_dn);
  wire m2a = c2_step & (c2_reg == ga2_reg);
  wire m2b = c2_step & (c2_reg == gb2_reg);
  wire c2_clr = (m2a & (clr2_reg == cpp_pkg::CLR_GA)) | (m2b & (clr2_reg == cpp_pkg::CLR_GB));
  wire c2_wrap = c2_step & ~c2_clr & (q_up ? (&c2_reg) : (c2_reg == cpp_pkg::CNT_RST));

  // Status flags: hardware set wins over software clear by writing 0
  assign stat_set = {c2_wrap, m2b, m2a, underflow, turn_down};
  assign stat_next = (stat_reg & ~(wr_stat ? ~hwdata[4:0] : 5'h00)) | stat_set;

  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[7:0] == cpp_pkg::ADDR_CTRL) begin
      rd_mux = ctrl_reg;
    end else if (haddr[7:0] == cpp_pkg::ADDR_STAT) begin
      rd_mux = {23'h00_0000, dir_reg, 3'h0, stat_reg};
    end else if (haddr[7:0] == cpp_pkg::ADDR_C3) begin
      rd_mux[CW-1:0] = c3_reg;
    end else if (haddr[7:0] == cpp_pkg::ADDR_C4) begin
      rd_mux[CW-1:0] = c4_reg;
    end else if (haddr[7:0] == cpp_pkg::ADDR_PER) begin
      rd_mux[CW-1:0] = per_reg;
    end else if (haddr[7:0] == cpp_pkg::ADDR_PT1) begin
      rd_mux[CW-1:0] = pt_reg[0];
    end else if (haddr[7:0] == 8'(cpp_pkg::ADDR_PT1 + cpp_pkg::ADDR_STEP)) begin
      rd_mux[CW-1:0] = pt_reg[1];
    end else if (haddr[7:0] == 8'(cpp_pkg::ADDR_PT1 + 2 * cpp_pkg::ADDR_STEP)) begin
      rd_mux[CW-1:0] = pt_reg[2];
    end else if (haddr[7:0] == cpp_pkg::ADDR_BF1) begin
      rd_mux[CW-1:0] = bf_reg[0];
    end else if (haddr[7:0] == 8'(cpp_pkg::ADDR_BF1 + cpp_pkg::ADDR_STEP)) begin
      rd_mux[CW-1:0] = bf_reg[1];
    end else if (haddr[7:0] == 8'(cpp_pkg::ADDR_BF1 + 2 * cpp_pkg::ADDR_STEP)) begin
      rd_mux[CW-1:0] = bf_reg[2];
    end else if (haddr[7:0] == cpp_pkg::ADDR_C2) begin
      rd_mux[CW-1:0] = c2_reg;
    end else if (haddr[7:0] == cpp_pkg::ADDR_C2GA) begin
      rd_mux[CW-1:0] = ga2_reg;
    end else if (haddr[7:0] == cpp_pkg::ADDR_C2GB) begin
      rd_mux[CW-1:0] = gb2_reg;
    end else if (haddr[7:0] == cpp_pkg::ADDR_C2CTRL) begin
      rd_mux[1:0] = clr2_reg;
    end
  end

  // Bus phases, control, prescaler and flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wa_reg <= 8'h00;
      rd_reg <= 32'h0000_0000;
      ctrl_reg <= cpp_pkg::CTRL_RST;
      clr2_reg <= cpp_pkg::CLR_NONE;
      div_reg <= 3'h0;
      stat_reg <= 5'h00;
    end else begin
      wr_pend_reg <= take & hwrite;
      wa_reg <= haddr[7:0];
      if (take & ~hwrite) begin
        rd_reg <= rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_reg <= hwdata;
      end
      if (wr_clr2) begin
        clr2_reg <= hwdata[1:0];
      end
      div_reg <= div_reg + 3'h1;
      stat_reg <= stat_next;
    end
  end

  // Channel 3/4 up/down counters with overshoot and undershoot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c3_reg <= cpp_pkg::CNT_RST;
      c4_reg <= cpp_pkg::CNT_RST;
      per_reg <= cpp_pkg::GR_RST;
      dir_reg <= cpp_pkg::CPP_UP;
    end else begin
      if (wr_c3) begin
        c3_reg <= wdat;
      end else if (step) begin
        c3_reg <= up ? c3_reg + 1'b1 : c3_reg - 1'b1;
      end
      if (wr_c4) begin
        c4_reg <= wdat;
      end else if (step) begin
        c4_reg <= up ? c4_reg + 1'b1 : c4_reg - 1'b1;
      end
      if (wr_per) begin
        per_reg <= wdat;
      end
      if (!comp_mode) begin
        dir_reg <= cpp_pkg::CPP_UP;
      end else if (turn_down) begin
        dir_reg <= cpp_pkg::CPP_DOWN;
      end else if (underflow) begin
        dir_reg <= cpp_pkg::CPP_UP;
      end
    end
  end

  // Points, buffers and output pairs; dead time from the counter offset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pt_reg <= '{default: cpp_pkg::GR_RST};
      bf_reg <= '{default: cpp_pkg::GR_RST};
      pos_reg <= 3'b000;
      neg_reg <= 3'b111;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_pt[i]) begin
          pt_reg[i] <= wdat;
        end else if (xfer) begin
          pt_reg[i] <= bf_reg[i];
        end
        if (wr_bf[i]) begin
          bf_reg[i] <= wdat;
        end
        if (!comp_mode) begin
          pos_reg[i] <= 1'b0;
          neg_reg[i] <= 1'b1;
        end else if (up) begin
          pos_reg[i] <= pos_reg[i] | m4[i];
          neg_reg[i] <= neg_reg[i] & ~m3[i];
        end else begin
          // Down: lower channel 4 meets the point first, so it drops the positive
          pos_reg[i] <= pos_reg[i] & ~m4[i];
          neg_reg[i] <= neg_reg[i] | m3[i];
        end
      end
    end
  end

  // Channel 2 phase counter with compare and clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c2_reg <= cpp_pkg::CNT_RST;
      ga2_reg <= cpp_pkg::GR_RST;
      gb2_reg <= cpp_pkg::GR_RST;
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
    end else begin
      a_prev_reg <= quad_input_a;
      b_prev_reg <= quad_input_b;
      if (wr_c2) begin
        c2_reg <= wdat;
      end else if (c2_clr) begin
        c2_reg <= cpp_pkg::CNT_RST;
      end else if (c2_step) begin
        c2_reg <= q_up ? c2_reg + 1'b1 : c2_reg - 1'b1;
      end
      if (wr_ga2) begin
        ga2_reg <= wdat;
      end
      if (wr_gb2) begin
        gb2_reg <= wdat;
      end
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_turn_down: assert property (turn_down |=> !up ##0 c3_reg == $past(per_reg) + 1'b1)
    else $error("no turn to down-counting at period match");
  a_turn_up: assert property (underflow |=> up && (&c4_reg))
    else $error("no turn to up-counting at underflow");
  a_match_flag: assert property ($rose(stat_reg[0]) |-> $past(step && up))
    else $error("match A flag set outside up-counting");
  a_ovf_flag: assert property ($rose(stat_reg[1]) |-> $past(underflow))
    else $error("overflow flag set without underflow");
  a_buf_xfer: assert property (xfer && !wr_pt[0] |=> pt_reg[0] == $past(bf_reg[0]))
    else $error("buffer not transferred at turn");
  a_no_overlap: assert property (comp_run |-> (pos_reg & neg_reg) == 3'b000)
    else $error("both outputs of a pair active");
  a_hold_off: assert property (!comp_run && !wr_c3 |=> $stable(c3_reg))
    else $error("channel 3 counted outside complementary mode");
  a_quad_up: assert property (ph_run && $rose(quad_input_a) && quad_input_b && !$changed(quad_input_b)
    && !c2_clr && !wr_c2 |=> c2_reg == $past(c2_reg) + 1'b1)
    else $error("quadrature up edge not counted");
  a_quad_down: assert property (ph_run && $fell(quad_input_b) && !quad_input_a
    && !$changed(quad_input_a) && !c2_clr && !wr_c2 |=> c2_reg == $past(c2_reg) - 1'b1)
    else $error("quadrature down edge not counted");
endmodule

// >>> tb/cpp_enc_model.sv
// Quadrature encoder model feeding the two phase counting inputs
`timescale 1ns/1ps
module cpp_enc_model (
  input wire logic clk,
  output logic qa,
  output logic qb
);
  logic [1:0] ph = 2'd0;

  // Gray order of (a,b) when turning forward: 00, 01, 11, 10
  function automatic logic [1:0] code(input logic [1:0] p);
    case (p)
      2'd0: code = 2'b00;
      2'd1: code = 2'b01; // B rises, A low
      2'd2: code = 2'b11; // A rises, B high
      default: code = 2'b10; // B falls, A high
    endcase
  endfunction

  initial begin
    qa = 1'b0;
    qb = 1'b0;
  end

  // One line moves per step, then both hold for 4 clocks
  task automatic step(input logic up);
    @(posedge clk);
    ph = up ? ph + 2'd1 : ph - 2'd1;
    {qa, qb} <= code(ph);
    repeat (4) @(posedge clk);
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the complementary PWM and phase counting timer
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pwm_oe, qa, qb;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  cpp_pkg::cpp_pwm_t pwm;
  int fail_count = 0;
  int n_checks = 0;
  int ovl = 0;
  int dead = 0;
  int hi1 = 0;
  int hi2 = 0;
  int hi3 = 0;
  int mx = 0;
  int dn = 0;

  cpp_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .quad_input_a(qa),
    .quad_input_b(qb), .pwm(pwm), .pwm_oe(pwm_oe));
  cpp_enc_model enc (.clk(hclk), .qa(qa), .qb(qb));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Watch pairs for overlap and activity, pair 2 for dead time, while the pins are driven
  always @(posedge hclk) begin
    if (pwm_oe === 1'b1) begin
      ovl += int'((pwm.out1 & pwm.out1_comp) | (pwm.out2 & pwm.out2_comp));
      ovl += int'(pwm.out3 & pwm.out3_comp);
      dead += int'(!pwm.out2 && !pwm.out2_comp);
      hi1 += int'(pwm.out1);
      hi2 += int'(pwm.out2);
      hi3 += int'(pwm.out3);
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #200000;
    $display("mismatch watchdog expected done seen hang");
    fail_count++;
    final_report;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask

  // Single AHB-Lite word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), q, e);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset state and unmapped place
    chk("pwm idle", 32'(pwm), 32'h0000_0015);
    chk("pwm_oe", 32'(pwm_oe), 32'h0000_0000);
    rc(cpp_pkg::ADDR_CTRL, 32'h0000_0000);
    rc(cpp_pkg::ADDR_PER, 32'h0000_FFFF);
    wr(8'h3C, 32'h1234_5678);
    rc(8'h3C, 32'h0000_0000);
    // Phase counting, prescaler setting must not matter
    wr(cpp_pkg::ADDR_CTRL, 32'h0000_0030);
    repeat (4) enc.step(1'b1);
    rc(cpp_pkg::ADDR_C2, 32'h0000_0004);
    wr(cpp_pkg::ADDR_CTRL, 32'h0000_0330);
    repeat (6) enc.step(1'b0);
    rc(cpp_pkg::ADDR_C2, 32'h0000_FFFE);
    bus(1'b0, cpp_pkg::ADDR_STAT, 32'h0000_0000);
    chk("ch2 underflow flag", 32'(q[cpp_pkg::ST_OVF2]), 32'h0000_0001);
    // Flags clear by writing 0; compare A clears the phase counter
    wr(cpp_pkg::ADDR_STAT, 32'h0000_0000);
    rc(cpp_pkg::ADDR_STAT, 32'h0000_0000);
    wr(cpp_pkg::ADDR_C2, 32'h0000_0000);
    wr(cpp_pkg::ADDR_C2GA, 32'h0000_0002);
    wr(cpp_pkg::ADDR_C2CTRL, 32'h0000_0001);
    repeat (3) enc.step(1'b1);
    rc(cpp_pkg::ADDR_C2, 32'h0000_0000);
    rc(cpp_pkg::ADDR_STAT, 32'h0000_0004);
    wr(cpp_pkg::ADDR_CTRL, 32'h0000_0000);
    // Complementary mode, margin 2, period 9, phase 1 out of range
    wr(cpp_pkg::ADDR_C3, 32'h0000_0002);
    wr(cpp_pkg::ADDR_C4, 32'h0000_0000);
    wr(cpp_pkg::ADDR_PER, 32'h0000_0009);
    wr(cpp_pkg::ADDR_PT1, 32'h0000_0020);
    wr(8'h18, 32'h0000_0005);
    wr(8'h1C, 32'h0000_0007);
    wr(cpp_pkg::ADDR_CTRL, 32'h0000_000E);
    @(posedge hclk);
    chk("pwm_oe on", 32'(pwm_oe), 32'h0000_0001);
    for (int i = 0; i < 40; i++) begin
      bus(1'b0, cpp_pkg::ADDR_C3, 32'h0000_0000);
      if (int'(q) > mx) mx = int'(q);
      bus(1'b0, cpp_pkg::ADDR_STAT, 32'h0000_0000);
      dn |= int'(q[cpp_pkg::ST_DIR]);
    end
    chk("ch3 top", 32'(mx inside {[8:10]}), 32'h0000_0001);
    chk("down seen", 32'(dn), 32'h0000_0001);
    chk("overlap", 32'(ovl), 32'h0000_0000);
    chk("dead time", 32'(dead > 0), 32'h0000_0001);
    chk("out1 0 duty", 32'(hi1), 32'h0000_0000);
    chk("out2 active", 32'(hi2 > 0), 32'h0000_0001);
    chk("out3 active", 32'(hi3 > 0), 32'h0000_0001);
    bus(1'b0, cpp_pkg::ADDR_STAT, 32'h0000_0000);
    chk("match a flag", 32'(q[cpp_pkg::ST_MATCH_A3]), 32'h0000_0001);
    chk("underflow flag", 32'(q[cpp_pkg::ST_OVF4]), 32'h0000_0001);
    // Buffered change brings phase 1 into range
    wr(8'h24, 32'h0000_0005);
    wr(8'h28, 32'h0000_0007);
    wr(cpp_pkg::ADDR_BF1, 32'h0000_0004);
    wr(cpp_pkg::ADDR_CTRL, 32'h0000_004E);
    hi1 = 0;
    repeat (60) @(posedge hclk);
    rc(cpp_pkg::ADDR_PT1, 32'h0000_0004);
    chk("out1 active", 32'(hi1 > 0), 32'h0000_0001);
    // Leave the mode, wait, then stop the counters
    wr(cpp_pkg::ADDR_CTRL, 32'h0000_000C);
    repeat (4) @(posedge hclk);
    wr(cpp_pkg::ADDR_CTRL, 32'h0000_0000);
    @(posedge hclk);
    chk("pwm_oe off", 32'(pwm_oe), 32'h0000_0000);
    chk("pwm idle end", 32'(pwm), 32'h0000_0015);
    chk("hresp", 32'(hresp), 32'h0000_0000);
    final_report;
  end
endmodule
